//--- rtl/adc_status_cfg.svh
`ifndef ADC_STATUS_CFG_SVH
`define ADC_STATUS_CFG_SVH
// register offsets on the serial control port
`define OFS_SLOT_BASE   8'h30
`define OFS_SLOT_SEVEN  8'h37
`define OFS_EVENT_FLAGS 8'h38
`define OFS_EVENT_MASK  8'h39
// field positions inside event_flags, except the unread enable at bit 4, which is in the mask only
`define POS_OVER_LSB    16
`define POS_UNDER_LSB   8
`define POS_GAIN_OVR    7
`define POS_UNREAD_IE   4
`define POS_WAIT_DONE   3
`define POS_CAL_READY   2
`define POS_SEQ_READY   1
`define POS_CONV_READY  0
// writable bits of the enable mask; bits 6 and 5 do not exist
`define MASK_WRITABLE   24'hffff9f
// reset values and the slot seven index
`define RST_WORD        24'h000000
`define RST_CHAN        8'h00
`define SLOT_SEVEN_IDX  3'h7
`endif

//--- rtl/adc_status_pkg.sv
`default_nettype none
package adc_status_pkg;
  typedef logic [23:0] word_t;
  typedef logic [7:0]  chan_vec_t;
  typedef logic [2:0]  idx_t;
endpackage
`default_nettype wire

//--- rtl/adc_status_flag_logic.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_status_cfg.svh"

module adc_status_flag_logic
  import adc_status_pkg::*;
(
  input  wire logic sys_clk,                  // 100 MHz device clock
  input  wire logic srst,                     // synchronous reset, high
  input  wire logic reg_wr,                   // host register write strobe
  input  wire logic reg_rd,                   // host register read strobe
  input  wire logic [7:0] reg_addr,           // register offset
  input  wire word_t reg_wdata,               // write data
  output word_t     reg_rdata,                // read data, one cycle after reg_rd
  input  wire logic result_valid,             // a conversion has finished
  input  wire word_t result_data,             // finished conversion result
  input  wire idx_t result_channel,           // channel of that result
  input  wire logic in_sequence,              // sequencer owns the destination
  input  wire idx_t result_destination_select,    // slot picked by the host
  input  wire idx_t sequencer_destination_select, // slot picked by the sequencer
  input  wire word_t upper_limit_setting,     // upper threshold
  input  wire word_t lower_limit_setting,     // lower threshold
  input  wire logic digital_overflow,         // result saturated high
  input  wire logic digital_underflow,        // result saturated low
  input  wire logic gain_cal_done,            // system gain calibration finished
  input  wire logic gain_cal_overrange,       // coefficient would exceed max code
  input  wire logic cal_stored,               // new calibration results stored
  input  wire logic cal_launch_wr,            // calibration start register written
  input  wire logic wait_finished,            // timed wait completed
  input  wire logic wait_launch_wr,           // wait start register written
  input  wire logic seq_pass_done,            // sequence finished one pass
  input  wire logic seq_wraparound,           // sequence step 52 back to 0
  input  wire logic sequence_launch_register, // sequence start register written
  input  wire logic conversion_launch_register, // conversion start register written
  input  wire logic pre_result_clear,         // continuous mode: result about to land
  output logic      unread_data_any,          // some slot holds unread data
  output logic      interrupt_output_n        // interrupt, active low
);

  // ****************************************
  // decode
  // ****************************************
  logic stat_rd;
  logic slot7_wr;
  logic mask_wr;
  logic slot7_load;
  idx_t target_idx;
  logic is_over;
  logic is_under;

  assign stat_rd    = reg_rd && (reg_addr == `OFS_EVENT_FLAGS);
  assign slot7_wr   = reg_wr && (reg_addr == `OFS_SLOT_SEVEN);
  assign mask_wr    = reg_wr && (reg_addr == `OFS_EVENT_MASK);
  assign target_idx = in_sequence ? sequencer_destination_select
                                  : result_destination_select;
  assign slot7_load = result_valid && (target_idx == `SLOT_SEVEN_IDX);
  // unsigned compare; the limits share the result coding
  assign is_over    = (result_data > upper_limit_setting) || digital_overflow;
  assign is_under   = (result_data < lower_limit_setting) || digital_underflow;

  // ****************************************
  // state
  // ****************************************
  word_t     slot7_q, slot7_d;
  word_t     mask_q, mask_d;
  word_t     rdata_q, rdata_d;
  chan_vec_t over_q, over_d;
  chan_vec_t under_q, under_d;
  chan_vec_t unread_q, unread_d;
  logic      gain_ovr_q, gain_ovr_d;
  logic      wait_q, wait_d;
  logic      cal_q, cal_d;
  logic      seq_q, seq_d;
  logic      conv_q, conv_d;
  logic      int_n_q, int_n_d;
  word_t     status_word;
  word_t     pending;

  assign status_word = {over_q, under_q, gain_ovr_q, 3'h0,
                        wait_q, cal_q, seq_q, conv_q};
  // unread indication sits outside event_flags but may still raise the line
  assign pending = (status_word | ({23'h0, |unread_q} << `POS_UNREAD_IE)) & mask_q;

  // ****************************************
  // per-slot unread flags
  // ****************************************
  for (genvar s = 0; s < 8; s++) begin : g_slot
    logic slot_rd;
    logic slot_set;
    assign slot_rd  = reg_rd && (reg_addr == (`OFS_SLOT_BASE + 8'(s)));
    assign slot_set = result_valid && (target_idx == 3'(s));
    // set wins so a result landing during its own read is not lost
    assign unread_d[s] = slot_set || (unread_q[s] && !slot_rd);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    slot7_d = slot7_q;
    if (slot7_load) begin
      slot7_d = result_data;
    end else if (slot7_wr) begin
      slot7_d = reg_wdata;
    end
    mask_d = mask_q;
    if (mask_wr) begin
      mask_d = reg_wdata & `MASK_WRITABLE;
    end
    // clears first, sets after, so a coincident set survives
    over_d   = stat_rd ? `RST_CHAN : over_q;
    under_d  = stat_rd ? `RST_CHAN : under_q;
    gain_ovr_d = gain_ovr_q;
    if (stat_rd || (gain_cal_done && !gain_cal_overrange)) begin
      gain_ovr_d = 1'b0;
    end
    if (gain_cal_done && gain_cal_overrange) begin
      gain_ovr_d = 1'b1;
    end
    if (result_valid) begin
      over_d[result_channel]  = over_d[result_channel] | is_over;
      under_d[result_channel] = under_d[result_channel] | is_under;
    end
    wait_d = wait_finished ||
             (wait_q && !stat_rd && !wait_launch_wr);
    cal_d  = cal_stored ||
             (cal_q && !stat_rd && !cal_launch_wr);
    seq_d  = seq_pass_done ||
             (seq_q && !stat_rd && !sequence_launch_register
                    && !seq_wraparound);
    conv_d = result_valid ||
             (conv_q && !stat_rd && !conversion_launch_register
                     && !pre_result_clear);
    // slots 0 to 6 live elsewhere; their reads only retire the unread flag here
    rdata_d = `RST_WORD;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_SLOT_SEVEN:  rdata_d = slot7_q;
        `OFS_EVENT_FLAGS: rdata_d = status_word;
        `OFS_EVENT_MASK:  rdata_d = mask_q;
        default:          rdata_d = `RST_WORD;
      endcase
    end
    // registered so the pin never glitches while flags and mask settle
    int_n_d = !(|pending);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      slot7_q  <= `RST_WORD;
      mask_q   <= `RST_WORD;
      rdata_q  <= `RST_WORD;
      over_q   <= `RST_CHAN;
      under_q  <= `RST_CHAN;
      unread_q <= `RST_CHAN;
      gain_ovr_q <= 1'b0;
      wait_q   <= 1'b0;
      cal_q    <= 1'b0;
      seq_q    <= 1'b0;
      conv_q   <= 1'b0;
      int_n_q  <= 1'b1;
    end else begin
      slot7_q  <= slot7_d;
      mask_q   <= mask_d;
      rdata_q  <= rdata_d;
      over_q   <= over_d;
      under_q  <= under_d;
      unread_q <= unread_d;
      gain_ovr_q <= gain_ovr_d;
      wait_q   <= wait_d;
      cal_q    <= cal_d;
      seq_q    <= seq_d;
      conv_q   <= conv_d;
      int_n_q  <= int_n_d;
    end
  end

  assign reg_rdata          = rdata_q;
  assign unread_data_any    = |unread_q;
  assign interrupt_output_n = int_n_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // each flag but over and under (set only) is checked for its set and its clear separately, so a swapped
  // priority in the next-state logic shows up at once

  chk_slot7_load: assert property (
    slot7_load |=> slot7_q == $past(result_data))
    else $error("slot seven missed a result");

  chk_status_clear: assert property (
    stat_rd && !result_valid && !wait_finished |=> !conv_q && !wait_q)
    else $error("status read left a flag set");

  chk_over_set: assert property (
    result_valid && digital_overflow |=> over_q[$past(result_channel)])
    else $error("over flag not raised");

  chk_flags_sticky: assert property (
    !stat_rd |=> ((over_q & $past(over_q)) == $past(over_q)) &&
                 ((under_q & $past(under_q)) == $past(under_q)))
    else $error("range flag dropped without read");

  chk_under_set: assert property (
    result_valid && digital_underflow |=> under_q[$past(result_channel)])
    else $error("under flag not raised");

  chk_gain_flag: assert property (
    gain_cal_done && !gain_cal_overrange |=> !gain_ovr_q)
    else $error("gain overrange flag kept after valid calibration");

  chk_gain_set: assert property (
    gain_cal_done && gain_cal_overrange |=> gain_ovr_q)
    else $error("gain overrange flag not raised");

  chk_unread_set: assert property (
    result_valid |=> unread_q[$past(target_idx)])
    else $error("unread flag not set by a slot write");

  chk_unread_clear: assert property (
    reg_rd && reg_addr == `OFS_SLOT_SEVEN && !slot7_load |=> !unread_q[7])
    else $error("unread flag kept after slot read");

  chk_wait_launch: assert property (
    wait_launch_wr && !wait_finished |=> !wait_q)
    else $error("wait flag kept after wait launch");

  chk_cal_set: assert property (
    cal_stored |=> cal_q)
    else $error("calibration flag not raised");

  chk_cal_clear: assert property (
    cal_launch_wr && !cal_stored |=> !cal_q)
    else $error("calibration flag kept after launch");

  chk_seq_set: assert property (
    seq_pass_done |=> seq_q)
    else $error("sequence flag not raised");

  chk_conv_set: assert property (
    result_valid |=> conv_q)
    else $error("conversion flag not raised");

  chk_conv_pre: assert property (
    pre_result_clear && !result_valid |=> !conv_q)
    else $error("conversion flag kept before new result");

  chk_range_map: assert property (
    $past(stat_rd) |-> reg_rdata[23:16] == $past(over_q) &&
                       reg_rdata[15:8] == $past(under_q))
    else $error("range flags read back out of place");

  chk_int_quiet: assert property (
    !(|pending) |=> interrupt_output_n)
    else $error("interrupt asserted with no enabled flag");

  chk_unread_keep: assert property (
    stat_rd && unread_q[7] && !(reg_rd && reg_addr == `OFS_SLOT_SEVEN)
    |=> unread_data_any)
    else $error("status read cleared unread indication");

  chk_seq_wrap: assert property (
    seq_wraparound && !seq_pass_done |=> !seq_q)
    else $error("sequence flag kept over wraparound");

  chk_set_wins: assert property (
    stat_rd && wait_finished |=> wait_q ##1 (wait_q || $past(stat_rd) || $past(wait_launch_wr)))
    else $error("coincident wait event lost");

  chk_int_follow: assert property (
    (|pending) [*2] |=> !interrupt_output_n)
    else $error("interrupt not asserted for enabled flag");

  chk_reserved_zero: assert property (
    $past(stat_rd) |-> reg_rdata[6:4] == 3'h0)
    else $error("reserved status bits not zero");

endmodule
`default_nettype wire

//--- dv/host_port_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// host side of the register port
// ****************************************
module host_port_model
  import adc_status_pkg::*;
(
  input  wire logic  sys_clk,   // device clock
  output logic       reg_wr,    // write strobe
  output logic       reg_rd,    // read strobe
  output logic [7:0] reg_addr,  // register offset
  output word_t      reg_wdata, // write data
  input  wire word_t reg_rdata  // read data
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hff;
    reg_wdata = 24'h000000;
  end
  task automatic acc(input logic w, input logic [7:0] a, input word_t d, output word_t q);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // idle lines must not keep the last value, or a stale decode would pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge sys_clk);
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- dv/adc_status_flag_logic_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
// ****************************************
// bench for the status and slot-seven logic
// ****************************************
module adc_status_flag_logic_tb_top
  import adc_status_pkg::*;
;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [10:0] ev = '0;
  logic ovr = 1'b0, ovf = 1'b0, unf = 1'b0, inseq = 1'b0;
  idx_t ch = 3'h0, rdest = 3'h7, sdest = 3'h7;
  word_t din = 24'h000000, q;
  logic reg_wr, reg_rd, unread, irq_n;
  logic [7:0] reg_addr;
  word_t reg_wdata, reg_rdata;
  word_t up_lim = 24'h000100, lo_lim = 24'h000010;
  int error_cnt = 0, checks_done = 0;
  logic [10:0] set_ev [6] = '{11'h001, 11'h004, 11'h010, 11'h010, 11'h400, 11'h400};
  logic [10:0] clr_ev [6] = '{11'h002, 11'h008, 11'h020, 11'h040, 11'h080, 11'h100};
  word_t flag [6] = '{24'h000008, 24'h000004, 24'h000002, 24'h000002, 24'h000001, 24'h000001};
  initial forever #5 sys_clk = ~sys_clk;
  host_port_model u_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  adc_status_flag_logic dut (.sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .result_valid(ev[10]), .result_data(din), .result_channel(ch), .in_sequence(inseq),
    .result_destination_select(rdest), .sequencer_destination_select(sdest),
    .upper_limit_setting(up_lim), .lower_limit_setting(lo_lim),
    .digital_overflow(ovf), .digital_underflow(unf), .gain_cal_done(ev[9]),
    .gain_cal_overrange(ovr), .cal_stored(ev[2]), .cal_launch_wr(ev[3]),
    .wait_finished(ev[0]), .wait_launch_wr(ev[1]), .seq_pass_done(ev[4]),
    .seq_wraparound(ev[5]), .sequence_launch_register(ev[6]),
    .conversion_launch_register(ev[7]), .pre_result_clear(ev[8]),
    .unread_data_any(unread), .interrupt_output_n(irq_n));
  task automatic rd(input logic [7:0] a, input word_t e);
    u_host.acc(1'b0, a, 24'h000000, q);
    `CHK(q, e)
  endtask
  task automatic wr(input logic [7:0] a, input word_t d);
    u_host.acc(1'b1, a, d, q);
  endtask
  task automatic pulse(input logic [10:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= '0;
  endtask
  task automatic res(input idx_t c, input word_t d, input logic o, input logic u);
    @(posedge sys_clk);
    ch <= c;
    din <= d;
    ovf <= o;
    unf <= u;
    ev <= 11'h400;
    @(posedge sys_clk);
    ev <= '0;
    ovf <= 1'b0;
    unf <= 1'b0;
  endtask
  task automatic close_out;
    $display("mismatches %0d of %0d checks", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    rd(8'h38, 24'h000000);
    rd(8'h37, 24'h000000);
    res(3'h2, 24'h000080, 1'b1, 1'b0);
    #1 `CHK(unread, 1'b1)
    rd(8'h38, 24'h040001);
    `CHK(unread, 1'b1)
    rd(8'h37, 24'h000080);
    `CHK(unread, 1'b0)
    rd(8'h38, 24'h000000);
    inseq <= 1'b1;
    rdest <= 3'h0;
    res(3'h5, 24'h000200, 1'b0, 1'b0);
    res(3'h5, 24'h000080, 1'b0, 1'b0);
    res(3'h1, 24'h000008, 1'b0, 1'b0);
    res(3'h3, 24'h000080, 1'b0, 1'b1);
    rd(8'h38, 24'h200a01);
    rd(8'h37, 24'h000080);
    inseq <= 1'b0;
    rdest <= 3'h3;
    res(3'h0, 24'h000040, 1'b0, 1'b0);
    #1 `CHK(unread, 1'b1)
    rd(8'h33, 24'h000000);
    `CHK(unread, 1'b0)
    up_lim <= 24'h000040;
    lo_lim <= 24'h000040;
    res(3'h4, 24'h000041, 1'b0, 1'b0);
    res(3'h6, 24'h000040, 1'b0, 1'b0);
    res(3'h2, 24'h00003f, 1'b0, 1'b0);
    rd(8'h38, 24'h100401);
    up_lim <= 24'h000100;
    lo_lim <= 24'h000010;
    for (int i = 0; i < 6; i++) begin
      pulse(set_ev[i]);
      rd(8'h38, flag[i]);
      pulse(set_ev[i]);
      pulse(clr_ev[i]);
      rd(8'h38, 24'h000000);
    end
    pulse(11'h003);
    rd(8'h38, 24'h000008);
    fork
      pulse(11'h001);
      rd(8'h38, 24'h000000);
    join
    rd(8'h38, 24'h000008);
    ovr <= 1'b1;
    pulse(11'h200);
    rd(8'h38, 24'h000080);
    pulse(11'h200);
    ovr <= 1'b0;
    pulse(11'h200);
    rd(8'h38, 24'h000000);
    wr(8'h38, 24'hffffff);
    rd(8'h38, 24'h000000);
    wr(8'h39, 24'hffffff);
    rd(8'h39, 24'hffff9f);
    `CHK(irq_n, 1'b0)
    wr(8'h37, 24'habcdef);
    rd(8'h37, 24'habcdef);
    rd(8'h3a, 24'h000000);
    wr(8'h39, 24'h000008);
    pulse(11'h001);
    #1 `CHK(irq_n, 1'b1)
    @(posedge sys_clk);
    #1 `CHK(irq_n, 1'b0)
    rd(8'h38, 24'h000008);
    @(posedge sys_clk);
    #1 `CHK(irq_n, 1'b1)
    wr(8'h39, 24'h000004);
    pulse(11'h001);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(irq_n, 1'b1)
    close_out();
  end
endmodule
`default_nettype wire
